// ==== pss_pkg.sv ====
// Purpose: Shared constants for the pulse step sequencer
// Assumes: 100 MHz system clock
// Notes:   Step record layout is nine words per step
`default_nettype none
package pss_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;

  // ----------------------------------------------------------------
  // Program store layout
  // ----------------------------------------------------------------
  localparam int WORDS_PER_STEP = 9;
  localparam int HEADER_WORDS   = 2;
  localparam int W_KIND   = 0;
  localparam int W_TSRC   = 1;
  localparam int W_TVAL   = 2;
  localparam int W_PCLS   = 3;
  localparam int W_PIDX   = 4;
  localparam int W_NSEL   = 5;
  localparam int W_NVAL   = 6;
  localparam int W_STROKE = 7;
  localparam int W_SPARE  = 8;

  // Step kinds
  localparam logic [15:0] KIND_WAIT_TIME = 16'h0000;
  localparam logic [15:0] KIND_WAIT_PT   = 16'h0001;
  localparam logic [15:0] KIND_ACT       = 16'h0002;
  localparam logic [15:0] KIND_TRIG      = 16'h0003;
  localparam logic [15:0] KIND_END       = 16'h000f;

  // Point classes
  localparam logic [1:0] PT_INPUT  = 2'h0;
  localparam logic [1:0] PT_OUTPUT = 2'h1;
  localparam logic [1:0] PT_RELAY  = 2'h2;
  localparam logic [1:0] PT_STEP   = 2'h3;
  localparam int NUM_INPUTS  = 256;
  localparam int NUM_OUTPUTS = 256;
  localparam int NUM_RELAYS  = 1912;
  localparam int NUM_STEPRL  = 1000;

  // Next-step selector codes
  localparam logic [1:0] NSEL_NEXT  = 2'h0;
  localparam logic [1:0] NSEL_CONST = 2'h1;
  localparam logic [1:0] NSEL_REG   = 2'h2;

  // Time source codes
  localparam logic [15:0] TSRC_CONST = 16'h0000;
endpackage
`default_nettype wire

// ==== pss_prog_mem.sv ====
// Purpose: Program store with registered read port
// Assumes: Single clock, write port loaded by the controller
// Notes:   Read data valid one cycle after address
`timescale 1ns/1ps
`default_nettype none
module pss_prog_mem #(
  parameter int AW = 10
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [15:0]   wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [15:0]   rdData
);
  logic [15:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ==== pss_sequencer.sv ====
// Purpose: Runs a stored positioning program step by step
// Assumes: Pulse generator reports done; point and data images are inputs
// Notes:   Step n record starts at HEADER_WORDS + (n-1)*WORDS_PER_STEP
//
// Notes on behaviour
// - Check wait condition only after pulses finish
// - Timed wait counts 0.01 s ticks
// - Durations from constant or data register
// - Input point wait until ON
// - Output point wait until ON
// - Internal relay wait until ON
// - Step relay wait until ON
// - Action step stops pulses after duration
// - Trigger ON mid-pulse abandons step immediately
// - Trigger OFF at pulse end acts as wait
// - Sequential selector goes to following step
// - Numbered selector jumps to that step
// - Register selector reads target at transfer
// - End marker stops fetching steps
// - Nine words per step, plus two
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int AW        = 10,
  parameter int TICK_CNT  = TICK_CYCLES,
  parameter int DREG_AW   = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   start,
  input  wire logic                   progWe,
  input  wire logic [AW-1:0]          progAddr,
  input  wire logic [15:0]            progData,
  input  wire logic [NUM_INPUTS-1:0]  inPoints,
  input  wire logic [NUM_OUTPUTS-1:0] outPoints,
  input  wire logic [NUM_RELAYS-1:0]  relayPoints,
  input  wire logic [NUM_STEPRL-1:0]  stepPoints,
  input  wire logic [15:0]            dataRegRd,
  output logic      [DREG_AW-1:0]     dataRegAddr,
  input  wire logic                   pulseDone,
  output logic                        pulseRun,
  output logic                        pulseAbort,
  output logic      [15:0]            stroke,
  output logic      [15:0]            curStep,
  output logic                        busy,
  output logic                        done
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_FETCH = 8'b0000_0010,
    S_LOAD  = 8'b0000_0100,
    S_RUN   = 8'b0000_1000,
    S_WAIT  = 8'b0001_0000,
    S_TNEXT = 8'b0010_0000,
    S_NEXT  = 8'b0100_0000,
    S_DONE  = 8'b1000_0000
  } pss_state_e;

  pss_state_e state_q;
  logic [3:0]    wIdx_q;
  logic [15:0]   rec_q [0:WORDS_PER_STEP-1];
  logic [31:0]   tickCnt_q;
  logic [15:0]   timeLeft_q;
  logic          timerOn_q;
  logic [AW-1:0] rdAddr;
  logic [15:0]   rdData;
  logic          tick;
  logic          pointOn;
  logic [15:0]   kind;
  logic          advance;
  logic          timeUp;
  pss_state_e state_d;
  logic          startOk;
  logic          recLast;
  logic          endSeen;
  logic          doneSet;
  logic          runEntry;
  logic          runBody;
  logic          leave;
  logic          strokeEnd;
  logic          tickDec;

  pss_prog_mem #(.AW(AW)) uMem (
    .clk    (clk),
    .we     (progWe),
    .wrAddr (progAddr),
    .wrData (progData),
    .rdAddr (rdAddr),
    .rdData (rdData)
  );

  // ----------------------------------------------------------------
  // Record addressing
  // ----------------------------------------------------------------
  // nine-word records
  assign rdAddr = AW'(HEADER_WORDS + (32'(curStep) - 1) * WORDS_PER_STEP + 32'(wIdx_q));
  assign kind   = rec_q[W_KIND];

  // ----------------------------------------------------------------
  // Point selection
  // ----------------------------------------------------------------
  always_comb begin
    pointOn = 1'b0;
    case (rec_q[W_PCLS][1:0])
      PT_INPUT:  pointOn = (rec_q[W_PIDX] < 16'(NUM_INPUTS)) && inPoints[rec_q[W_PIDX][7:0]];
      PT_OUTPUT: pointOn = (rec_q[W_PIDX] < 16'(NUM_OUTPUTS)) && outPoints[rec_q[W_PIDX][7:0]];
      PT_RELAY:  pointOn = (rec_q[W_PIDX] < 16'(NUM_RELAYS)) && relayPoints[rec_q[W_PIDX][10:0]];
      PT_STEP:   pointOn = (rec_q[W_PIDX] < 16'(NUM_STEPRL)) && stepPoints[rec_q[W_PIDX][9:0]];
      default:   pointOn = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // 0.01 s tick divider
  // ----------------------------------------------------------------
  // tick each 10 ms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_q <= 32'h0000_0000;
    end else if (!timerOn_q || tickCnt_q == 32'(TICK_CNT - 1)) begin
      tickCnt_q <= 32'h0000_0000;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
    end
  end
  assign tick   = timerOn_q && (tickCnt_q == 32'(TICK_CNT - 1));
  assign timeUp = timerOn_q && (timeLeft_q == 16'h0000);

  // Leave-step decision, evaluated in RUN and WAIT
  always_comb begin
    advance = 1'b0;
    if (state_q == S_RUN) begin
      case (kind)
        // leave on time, not stroke end
        KIND_ACT:  advance = timeUp;
        KIND_TRIG: advance = pointOn;
        default:   advance = 1'b0;
      endcase
    end else if (state_q == S_WAIT) begin
      case (kind)
        KIND_WAIT_TIME: advance = timeUp;
        // trigger after pulses acts as wait
        KIND_TRIG:      advance = pointOn;
        default:        advance = pointOn;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  assign startOk   = ((state_q == S_IDLE) || (state_q == S_DONE)) && start;
  assign recLast   = (state_q == S_LOAD) && (wIdx_q == 4'(WORDS_PER_STEP));
  assign endSeen   = (state_q == S_LOAD) && (wIdx_q == 4'h1) && (rdData == KIND_END);
  assign doneSet   = endSeen || (recLast && (rec_q[W_KIND] == KIND_END));
  assign runEntry  = (state_q == S_RUN) && (wIdx_q == 4'(WORDS_PER_STEP));
  assign runBody   = (state_q == S_RUN) && !runEntry;
  assign leave     = advance && !runEntry;
  assign strokeEnd = runBody && !advance && pulseDone;
  assign tickDec   = (runBody || (state_q == S_WAIT)) && tick && (timeLeft_q != 16'h0000);

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE, S_DONE: begin
        if (start) begin
          state_d = S_FETCH;
        end
      end
      S_FETCH: state_d = S_LOAD;
      S_LOAD: begin
        if (doneSet) begin
          state_d = S_DONE;
        end else if (recLast) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (leave) begin
          state_d = S_TNEXT;
        end else if (strokeEnd) begin
          // Action keeps timing after an early stroke end
          state_d = (kind == KIND_ACT) ? S_RUN : S_WAIT;
        end
      end
      S_WAIT: begin
        if (leave) begin
          state_d = S_TNEXT;
        end
      end
      S_TNEXT: state_d = S_NEXT;
      S_NEXT:  state_d = S_FETCH;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Index parks at the record end so RUN knows its entry cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wIdx_q <= 4'h0;
    end else if (startOk || runEntry || (state_q == S_NEXT)) begin
      wIdx_q <= 4'h0;
    end else if ((state_q == S_FETCH) || ((state_q == S_LOAD) && !recLast)) begin
      wIdx_q <= wIdx_q + 4'h1;
    end
  end

  // Read data lags its address by one cycle, hence index minus one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < WORDS_PER_STEP; i++) begin
        rec_q[i] <= 16'h0000;
      end
    end else if (state_q == S_LOAD) begin
      rec_q[wIdx_q - 4'h1] <= rdData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeLeft_q <= 16'h0000;
    end else if (runEntry) begin
      timeLeft_q <= (rec_q[W_TSRC] == TSRC_CONST) ? rec_q[W_TVAL] : dataRegRd;
    end else if (tickDec) begin
      timeLeft_q <= timeLeft_q - 16'h0001;
    end
  end

  // Action times from pulse start, timed wait from stroke end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerOn_q <= 1'b0;
    end else if (runEntry) begin
      timerOn_q <= (kind == KIND_ACT);
    end else if (leave) begin
      timerOn_q <= 1'b0;
    end else if (strokeEnd) begin
      timerOn_q <= (kind == KIND_WAIT_TIME) || (kind == KIND_ACT);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulseRun <= 1'b0;
      stroke   <= 16'h0000;
    end else if (runEntry) begin
      pulseRun <= 1'b1;
      stroke   <= rec_q[W_STROKE];
    end else if ((runBody && advance) || strokeEnd || doneSet) begin
      pulseRun <= 1'b0;
    end
  end

  // abort whenever RUN is left while pulseDone is low, also after an early action stroke end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulseAbort <= 1'b0;
    end else begin
      pulseAbort <= runBody && advance && !pulseDone;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataRegAddr <= '0;
    end else if (recLast) begin
      dataRegAddr <= DREG_AW'(rec_q[W_TVAL]);
    end else if (state_q == S_TNEXT) begin
      dataRegAddr <= DREG_AW'(rec_q[W_NVAL]);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      curStep <= 16'h0001;
    end else if (startOk) begin
      curStep <= 16'h0001;
    end else if (state_q == S_NEXT) begin
      case (rec_q[W_NSEL][1:0])
        NSEL_NEXT:  curStep <= curStep + 16'h0001;
        NSEL_CONST: curStep <= rec_q[W_NVAL];
        NSEL_REG:   curStep <= dataRegRd;
        default:    curStep <= curStep + 16'h0001;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else if (doneSet) begin
      done <= 1'b1;
    end else if (startOk) begin
      done <= 1'b0;
    end
  end

  assign busy = (state_q != S_IDLE) && (state_q != S_DONE);
endmodule
`default_nettype wire

// ==== pss_sequencer_chk.sv ====
// Purpose: Port assertions for pss_sequencer
// Assumes: One clock, async active-low reset
// Notes:   Bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        start,
  input wire logic        pulseDone,
  input wire logic        pulseRun,
  input wire logic        pulseAbort,
  input wire logic [15:0] curStep,
  input wire logic        busy,
  input wire logic        done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sLaunch;
    ##[1:40] (pulseRun || done);
  endsequence
  sequence sHalt;
    ##[0:2] !pulseRun;
  endsequence
  chk_start_runs: assert property ($rose(busy) |-> sLaunch)
    else $error("step not launched after start");
  chk_run_ends: assert property (pulseRun && pulseDone |-> sHalt)
    else $error("pulses run on after stroke end");
  chk_abort_halts: assert property (pulseAbort |-> sHalt)
    else $error("pulses run on after abort");
  chk_step_between: assert property ($changed(curStep) |-> !pulseRun)
    else $error("step changed during pulses");
  chk_done_quiet: assert property (done |-> !busy && !pulseRun)
    else $error("activity after end marker");
  chk_done_holds: assert property (done && !start |=> done)
    else $error("completion dropped without start");
  chk_run_busy: assert property (pulseRun |-> busy)
    else $error("pulses while idle");
  chk_step_valid: assert property (busy |-> curStep != 16'h0000)
    else $error("step number zero while running");
endmodule
bind pss_sequencer pss_sequencer_chk i_pss_sequencer_chk (.clk(clk), .rstn(rstn), .start(start),
  .pulseDone(pulseDone), .pulseRun(pulseRun), .pulseAbort(pulseAbort), .curStep(curStep),
  .busy(busy), .done(done));
`default_nettype wire

// ==== pss_drive_model.sv ====
// Purpose: Motor drive side, reports stroke end
// Assumes: Stroke length in cycles set by lenCyc
// Notes:   Abort or loss of run clears the stroke
`timescale 1ns/1ps
`default_nettype none
module pss_drive_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        pulseRun,
  input  wire logic        pulseAbort,
  input  wire logic [15:0] lenCyc,
  output var  logic        pulseDone
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= 16'h0000;
      pulseDone <= 1'b0;
    end else begin
      cnt_q     <= (pulseRun && !pulseAbort) ? cnt_q + 16'h0001 : 16'h0000;
      pulseDone <= pulseRun && !pulseAbort && (cnt_q >= lenCyc);
    end
  end
endmodule
`default_nettype wire

// ==== test_pss_sequencer.sv ====
// Purpose: Self-checking bench for pss_sequencer
// Assumes: TICK_CNT of 10 cycles per time unit
// Notes:   One program covers all step kinds
`timescale 1ns/1ps
`default_nettype none
module test_pss_sequencer;
  import pss_pkg::*;
  logic          clk = 1'b0, rstn = 1'b0, start = 1'b0, progWe = 1'b0;
  logic [9:0]    progAddr = 10'h000;
  logic [15:0]   progData = 16'h0000, lenCyc = 16'h0005;
  logic [255:0]  inP = '0, outP = '0;
  logic [1911:0] relP = '0;
  logic [999:0]  stpP = '0;
  logic [7:0]    dAddr;
  logic [15:0]   dRd, stroke, curStep;
  logic          pulseDone, pulseRun, pulseAbort, busy, done;
  int            n_fail = 0, comparisons = 0;
  always #5 clk = ~clk;
  // Register 3 holds action time, register 7 a next_step_select target
  assign dRd = (dAddr == 8'h03) ? 16'h0001 : (dAddr == 8'h07) ? 16'h0007 : 16'h0000;
  pss_sequencer #(.TICK_CNT(10)) i_pss_sequencer (.clk(clk), .rstn(rstn), .start(start), .progWe(progWe),
    .progAddr(progAddr), .progData(progData), .inPoints(inP), .outPoints(outP), .relayPoints(relP),
    .stepPoints(stpP), .dataRegRd(dRd), .dataRegAddr(dAddr), .pulseDone(pulseDone), .pulseRun(pulseRun),
    .pulseAbort(pulseAbort), .stroke(stroke), .curStep(curStep), .busy(busy), .done(done));
  pss_drive_model i_pss_drive_model (.clk(clk), .rstn(rstn), .pulseRun(pulseRun), .pulseAbort(pulseAbort),
    .lenCyc(lenCyc), .pulseDone(pulseDone));
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmpV(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic st(input int n, input logic [15:0] k, ts, tv, input logic [1:0] pc,
                    input logic [15:0] pi, input logic [1:0] ns, input logic [15:0] nv);
    logic [15:0] w [9];
    w = '{k, ts, tv, {14'h0000, pc}, pi, {14'h0000, ns}, nv, 16'h0064, 16'h0000};
    for (int i = 0; i < 9; i++) begin
      progAddr = 10'(HEADER_WORDS + (n - 1) * WORDS_PER_STEP + i);
      progData = w[i];
      cyc(1);
    end
  endtask
  task automatic t_timed();
    for (int i = 0; i < 60 && pulseDone !== 1'b1; i++) cyc(1);
    cyc(19);
    cmpV(curStep, 16'h0001, "timed wait left early");
    for (int i = 0; i < 40 && curStep !== 16'h0002; i++) cyc(1);
    cmpV(curStep, 16'h0002, "timed wait next");
    $display("timed wait test done");
  endtask
  task automatic t_point(input logic [15:0] s, input logic [15:0] nx, input int c);
    for (int i = 0; i < 80 && curStep !== s; i++) cyc(1);
    // Start while busy must be ignored
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(60);
    cmpV(curStep, s, "point wait did not hold");
    case (c)
      0: inP[255] = 1'b1;
      1: outP[255] = 1'b1;
      2: relP[1911] = 1'b1;
      default: stpP[999] = 1'b1;
    endcase
    for (int i = 0; i < 40 && curStep !== nx; i++) cyc(1);
    cmpV(curStep, nx, "point wait next");
    $display("point wait class %0d test done", c);
  endtask
  task automatic t_action();
    lenCyc = 16'h01f4;
    for (int i = 0; i < 60 && pulseRun !== 1'b1; i++) cyc(1);
    cmpV(stroke, 16'h0064, "stroke value");
    for (int i = 0; i < 60 && pulseAbort !== 1'b1; i++) cyc(1);
    cmpV({15'h0000, pulseAbort}, 16'h0001, "action not cut");
    for (int i = 0; i < 40 && curStep !== 16'h0008; i++) cyc(1);
    cmpV(curStep, 16'h0008, "action next");
    $display("action test done");
  endtask
  task automatic t_trigger();
    for (int i = 0; i < 60 && pulseRun !== 1'b1; i++) cyc(1);
    cyc(5);
    relP[0] = 1'b1;
    cyc(1);
    cmpV({14'h0000, pulseRun, pulseAbort}, 16'h0001, "trigger did not cut pulses");
    for (int i = 0; i < 30 && curStep !== 16'h0009; i++) cyc(1);
    cmpV(curStep, 16'h0009, "trigger not taken");
    lenCyc = 16'h0005;
    for (int i = 0; i < 80 && pulseDone !== 1'b1; i++) cyc(1);
    cyc(40);
    cmpV(curStep, 16'h0009, "trigger wait left");
    inP[0] = 1'b1;
    for (int i = 0; i < 80 && done !== 1'b1; i++) cyc(1);
    cmpV({15'h0000, done}, 16'h0001, "end not reported");
    cmpV({14'h0000, busy, pulseRun}, 16'h0000, "active after end");
    $display("trigger and end test done");
  endtask
  initial begin
    #50us;
    n_fail++;
    results();
  end
  initial begin
    cyc(5);
    rstn = 1'b1;
    progWe = 1'b1;
    st(1, KIND_WAIT_TIME, TSRC_CONST, 16'h0002, PT_INPUT, 16'h0000, NSEL_NEXT, 16'h0000);
    st(2, KIND_WAIT_PT, TSRC_CONST, 16'h0000, PT_INPUT, 16'h00ff, NSEL_CONST, 16'h0003);
    st(3, KIND_WAIT_PT, TSRC_CONST, 16'h0000, PT_OUTPUT, 16'h00ff, NSEL_NEXT, 16'h0000);
    st(4, KIND_WAIT_PT, TSRC_CONST, 16'h0000, PT_RELAY, 16'h0777, NSEL_NEXT, 16'h0000);
    st(5, KIND_WAIT_PT, TSRC_CONST, 16'h0000, PT_STEP, 16'h03e7, NSEL_REG, 16'h0007);
    st(6, KIND_END, TSRC_CONST, 16'h0000, PT_INPUT, 16'h0000, NSEL_NEXT, 16'h0000);
    st(7, KIND_ACT, 16'h0001, 16'h0003, PT_INPUT, 16'h0000, NSEL_NEXT, 16'h0000);
    st(8, KIND_TRIG, TSRC_CONST, 16'h0000, PT_RELAY, 16'h0000, NSEL_NEXT, 16'h0000);
    st(9, KIND_TRIG, TSRC_CONST, 16'h0000, PT_INPUT, 16'h0000, NSEL_NEXT, 16'h0000);
    st(10, KIND_END, TSRC_CONST, 16'h0000, PT_INPUT, 16'h0000, NSEL_NEXT, 16'h0000);
    progWe = 1'b0;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    t_timed();
    t_point(16'h0002, 16'h0003, 0);
    t_point(16'h0003, 16'h0004, 1);
    t_point(16'h0004, 16'h0005, 2);
    t_point(16'h0005, 16'h0007, 3);
    t_action();
    t_trigger();
    results();
  end
endmodule
`default_nettype wire
